// File: eef_pkg.sv
package eef_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_FLAG = 8'h08;
    localparam logic [7:0] OFS_IEN = 8'h0c;
    localparam logic [7:0] OFS_MAC = 8'h10;
    localparam logic [7:0] OFS_PCNT = 8'h14;
    localparam logic [7:0] OFS_PDEC = 8'h18;
    localparam logic [7:0] OFS_PHYC = 8'h1c;
    localparam logic [7:0] OFS_PHY_INT_STATUS_REG = 8'h20;
    localparam logic [7:0] OFS_TXND = 8'h24;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int B_TXREQ = 3;
    localparam int B_CPGO = 5;
    localparam int B_ABRT = 1;
    localparam int B_BUFFER_ACCESS_ERROR = 6;
    localparam int B_RXER = 0;
    localparam int B_TXER = 1;
    localparam int B_TXDN = 3;
    localparam int B_LINK = 4;
    localparam int B_CPDN = 5;
    localparam int B_PKT = 6;
    localparam int B_GIE = 7;
    localparam int B_FDX = 0;
    localparam int B_HUGE = 2;
    localparam int B_WAITF = 6;
    localparam int B_MXFL = 16;
    localparam int B_PHY_LINK_INT_ENABLE = 0;
    localparam int B_PHY_GLOBAL_INT_ENABLE = 1;
    localparam int B_PHY_GLOBAL_INT_FLAG = 2;
    localparam int B_PHY_LINK_INT_FLAG = 3;
    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] RST_MXFL = 16'h05ee;
    localparam logic [7:0] PKT_MAX = 8'hff;
    localparam logic [4:0] COLL_LIMIT = 5'h0f;
    localparam logic [10:0] LATE_BYTES = 11'h040;
    localparam logic [5:0] FLAG_MASK = 6'h3b;
endpackage

// File: eef_top.sv
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
module eef_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic rx_pkt_end,
    input wire logic rx_no_room,
    input wire logic rx_bw_fail,
    input wire logic tx_collision,
    input wire logic [10:0] tx_bytes_sent,
    input wire logic tx_wait_forever_on_busy_medium_limit,
    input wire logic [15:0] tx_frame_len,
    input wire logic per_packet_override,
    input wire logic per_packet_huge_allow,
    input wire logic tx_underrun,
    input wire logic tx_complete,
    input wire logic copy_engine_finished,
    input wire logic phy_link_event,
    output logic eth_irq,
    output logic tx_request,
    output logic copy_engine_go,
    output logic rx_abort,
    output logic tx_status_write,
    output logic [12:0] tx_status_addr
);
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic acc;
    logic wr_q;
    logic [7:0] wa_q;
    logic [31:0] rd_d;
    logic rd_phy_int_status_reg;
    logic wr_ctrl, wr_stat, wr_flag, wr_ien, wr_mac, wr_pdec, wr_phyc, wr_txnd;

    assign acc = hsel & hready & htrans[1];
    // reading the phy status word is the management read that re-arms
    assign rd_phy_int_status_reg = acc & ~hwrite & (haddr[7:0] == eef_pkg::OFS_PHY_INT_STATUS_REG)
        & (haddr[31:8] == 24'h000000);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end
        else
        begin
            wr_q <= acc & hwrite & (haddr[31:8] == 24'h000000);
            wa_q <= haddr[7:0];
        end
    end

    assign wr_ctrl = wr_q & (wa_q == eef_pkg::OFS_CTRL);
    assign wr_stat = wr_q & (wa_q == eef_pkg::OFS_STAT);
    assign wr_flag = wr_q & (wa_q == eef_pkg::OFS_FLAG);
    assign wr_ien = wr_q & (wa_q == eef_pkg::OFS_IEN);
    assign wr_mac = wr_q & (wa_q == eef_pkg::OFS_MAC);
    assign wr_pdec = wr_q & (wa_q == eef_pkg::OFS_PDEC);
    assign wr_phyc = wr_q & (wa_q == eef_pkg::OFS_PHYC);
    assign wr_txnd = wr_q & (wa_q == eef_pkg::OFS_TXND);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic txreq_q, txreq_d;
    logic cpgo_q, cpgo_d;
    logic abrt_q, buffer_access_error_q;
    logic rxer_q, txer_q, txdn_q, link_q, cpdn_q;
    logic [7:0] ien_q;
    logic fdx_q, huge_q, waitf_q;
    logic [15:0] mxfl_q;
    logic [7:0] pcnt_q;
    logic phy_link_int_enable_q, phy_global_int_enable_q, phy_link_int_flag_q;
    logic [12:0] txnd_q;
    logic [4:0] coll_q;
    logic phy_global_int_flag;
    logic rx_err_ev, tx_abort_ev, txreq_fall, cpgo_fall;
    logic coll_abort, wait_forever_on_busy_medium_abort, size_abort;
    logic rx_store;
    logic [5:0] flags;

    assign phy_global_int_flag = phy_link_int_flag_q & phy_link_int_enable_q & phy_global_int_enable_q;
    // rx rejects a finished packet when it has nowhere to go
    assign rx_store = rx_pkt_end & ~rx_no_room & (pcnt_q != eef_pkg::PKT_MAX);
    assign rx_err_ev = (rx_pkt_end & ~rx_store) | rx_bw_fail;

    // half duplex only: shared medium problems
    assign coll_abort = ~fdx_q & tx_collision
        & ((coll_q == eef_pkg::COLL_LIMIT) | (tx_bytes_sent > eef_pkg::LATE_BYTES));
    assign wait_forever_on_busy_medium_abort = ~fdx_q & tx_wait_forever_on_busy_medium_limit & ~waitf_q;
    assign size_abort = (tx_frame_len > mxfl_q) & ~huge_q
        & ~(per_packet_override & per_packet_huge_allow);
    assign tx_abort_ev = txreq_q
        & (coll_abort | wait_forever_on_busy_medium_abort | size_abort | tx_underrun);

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    always_comb
    begin
        txreq_d = txreq_q;
        if (wr_ctrl)
        begin
            txreq_d = hwdata[eef_pkg::B_TXREQ];
        end
        if (tx_abort_ev | (txreq_q & tx_complete))
        begin
            txreq_d = 1'b0;
        end
    end

    always_comb
    begin
        cpgo_d = cpgo_q;
        if (wr_ctrl)
        begin
            cpgo_d = hwdata[eef_pkg::B_CPGO];
        end
        if (cpgo_q & copy_engine_finished)
        begin
            cpgo_d = 1'b0;
        end
    end

    assign txreq_fall = txreq_q & ~txreq_d;
    assign cpgo_fall = cpgo_q & ~cpgo_d;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            txreq_q <= 1'b0;
            cpgo_q <= 1'b0;
        end
        else
        begin
            txreq_q <= txreq_d;
            cpgo_q <= cpgo_d;
        end
    end

    // collisions counted per packet; held at zero while no request is pending
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            coll_q <= 5'h00;
        end
        else if (~txreq_q)
        begin
            coll_q <= 5'h00;
        end
        else if (tx_collision & ~fdx_q)
        begin
            coll_q <= coll_q + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // status bits, write one to clear, set wins
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            abrt_q <= 1'b0;
            buffer_access_error_q <= 1'b0;
        end
        else
        begin
            abrt_q <= tx_abort_ev
                | (abrt_q & ~(wr_stat & hwdata[eef_pkg::B_ABRT]));
            buffer_access_error_q <= rx_bw_fail | (tx_underrun & txreq_q)
                | (buffer_access_error_q & ~(wr_stat & hwdata[eef_pkg::B_BUFFER_ACCESS_ERROR]));
        end
    end

    // ------------------------------------------------------------
    // event flags, write one to clear, set wins
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rxer_q <= 1'b0;
            txer_q <= 1'b0;
            txdn_q <= 1'b0;
            cpdn_q <= 1'b0;
        end
        else
        begin
            rxer_q <= rx_err_ev
                | (rxer_q & ~(wr_flag & hwdata[eef_pkg::B_RXER]));
            txer_q <= tx_abort_ev
                | (txer_q & ~(wr_flag & hwdata[eef_pkg::B_TXER]));
            txdn_q <= txreq_fall
                | (txdn_q & ~(wr_flag & hwdata[eef_pkg::B_TXDN]));
            cpdn_q <= cpgo_fall
                | (cpdn_q & ~(wr_flag & hwdata[eef_pkg::B_CPDN]));
        end
    end

    // ------------------------------------------------------------
    // phy link interrupt path
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phy_link_int_enable_q <= 1'b0;
            phy_global_int_enable_q <= 1'b0;
            phy_link_int_flag_q <= 1'b0;
            link_q <= 1'b0;
        end
        else
        begin
            if (wr_phyc)
            begin
                phy_link_int_enable_q <= hwdata[eef_pkg::B_PHY_LINK_INT_ENABLE];
                phy_global_int_enable_q <= hwdata[eef_pkg::B_PHY_GLOBAL_INT_ENABLE];
            end
            phy_link_int_flag_q <= phy_link_event | (phy_link_int_flag_q & ~rd_phy_int_status_reg);
            // no software write path: read-only flag
            link_q <= phy_global_int_flag & ~rd_phy_int_status_reg;
        end
    end

    // ------------------------------------------------------------
    // configuration and packet counter
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ien_q <= 8'h00;
            fdx_q <= 1'b0;
            huge_q <= 1'b0;
            waitf_q <= 1'b0;
            mxfl_q <= eef_pkg::RST_MXFL;
            txnd_q <= 13'h0000;
        end
        else
        begin
            if (wr_ien)
            begin
                ien_q <= hwdata[7:0];
            end
            if (wr_mac)
            begin
                fdx_q <= hwdata[eef_pkg::B_FDX];
                huge_q <= hwdata[eef_pkg::B_HUGE];
                waitf_q <= hwdata[eef_pkg::B_WAITF];
                mxfl_q <= hwdata[eef_pkg::B_MXFL +: 16];
            end
            if (wr_txnd)
            begin
                txnd_q <= hwdata[12:0];
            end
        end
    end

    // simultaneous store and decrement leave a nonzero count unchanged; at zero the store counts
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pcnt_q <= 8'h00;
        end
        else if (rx_store & ~(wr_pdec & (pcnt_q != 8'h00)))
        begin
            pcnt_q <= pcnt_q + 8'h01;
        end
        else if (~rx_store & wr_pdec & (pcnt_q != 8'h00))
        begin
            pcnt_q <= pcnt_q - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // interrupt and side outputs
    // ------------------------------------------------------------
    assign flags = {pcnt_q != 8'h00, cpdn_q, link_q, txdn_q, txer_q, rxer_q};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            eth_irq <= 1'b0;
            rx_abort <= 1'b0;
            tx_status_write <= 1'b0;
            tx_status_addr <= 13'h0000;
        end
        else
        begin
            // link flag already carries both phy enables
            eth_irq <= ien_q[eef_pkg::B_GIE]
                & (|({flags[5:2], 1'b0, flags[1:0]} & ien_q[6:0]));
            rx_abort <= rx_err_ev;
            tx_status_write <= tx_abort_ev;
            tx_status_addr <= txnd_q + 13'h0001;
        end
    end

    assign tx_request = txreq_q;
    assign copy_engine_go = cpgo_q;

    // ------------------------------------------------------------
    // read data, registered for the data phase
    // ------------------------------------------------------------
    always_comb
    begin
        rd_d = 32'h00000000;
        case (haddr[7:0])
            eef_pkg::OFS_CTRL: rd_d = {26'h0, cpgo_q, 1'b0, txreq_q, 3'h0};
            eef_pkg::OFS_STAT: rd_d = {25'h0, buffer_access_error_q, 4'h0, abrt_q, 1'b0};
            eef_pkg::OFS_FLAG: rd_d = {25'h0, flags[5:2], 1'b0, flags[1:0]};
            eef_pkg::OFS_IEN: rd_d = {24'h0, ien_q};
            eef_pkg::OFS_MAC: rd_d = {mxfl_q, 9'h0, waitf_q, 3'h0, huge_q, 1'b0, fdx_q};
            eef_pkg::OFS_PCNT: rd_d = {24'h0, pcnt_q};
            eef_pkg::OFS_PHYC: rd_d = {30'h0, phy_global_int_enable_q, phy_link_int_enable_q};
            eef_pkg::OFS_PHY_INT_STATUS_REG: rd_d = {28'h0, phy_link_int_flag_q, phy_global_int_flag, 2'h0};
            eef_pkg::OFS_TXND: rd_d = {19'h0, txnd_q};
            default: rd_d = 32'h00000000;
        endcase
        if (haddr[31:8] != 24'h000000)
        begin
            rd_d = 32'h00000000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            if (acc & ~hwrite)
            begin
                hrdata <= rd_d;
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_abort;
        tx_abort_ev;
    endsequence

    sequence s_abort_effects;
        ##1 (!txreq_q && abrt_q && txer_q && txdn_q && tx_status_write);
    endsequence

    property p_rx_room;
        @(posedge hclk) disable iff (!hresetn)
        (rx_pkt_end && !wr_pdec && pcnt_q == 8'hff) |=> (rxer_q && rx_abort && pcnt_q == 8'hff);
    endproperty
    a_rx_room: assert property (p_rx_room) else $error("full count not refused");

    property p_rx_sticky;
        @(posedge hclk) disable iff (!hresetn)
        (rxer_q && !(wr_flag && hwdata[0])) |=> rxer_q;
    endproperty
    a_rx_sticky: assert property (p_rx_sticky) else $error("rx error lost");

    property p_buffer_access_error;
        @(posedge hclk) disable iff (!hresetn)
        rx_bw_fail |=> (buffer_access_error_q && rxer_q);
    endproperty
    a_buffer_access_error: assert property (p_buffer_access_error) else $error("buffer error missing");

    property p_abort;
        @(posedge hclk) disable iff (!hresetn)
        s_abort |-> s_abort_effects;
    endproperty
    a_abort: assert property (p_abort) else $error("abort effects missing");

    property p_fdx;
        @(posedge hclk) disable iff (!hresetn)
        (fdx_q && !tx_underrun && !size_abort) |-> !tx_abort_ev;
    endproperty
    a_fdx: assert property (p_fdx) else $error("full duplex medium abort");

    property p_txdn_with_err;
        @(posedge hclk) disable iff (!hresetn)
        $rose(txer_q) |-> $rose(txdn_q) || $past(txdn_q);
    endproperty
    a_txdn_with_err: assert property (p_txdn_with_err) else $error("tx done late");

    property p_txdn_fall;
        @(posedge hclk) disable iff (!hresetn)
        $fell(txreq_q) |-> txdn_q;
    endproperty
    a_txdn_fall: assert property (p_txdn_fall) else $error("tx done not set");

    property p_link_gate;
        @(posedge hclk) disable iff (!hresetn)
        !(phy_link_int_enable_q && phy_global_int_enable_q) |=> !link_q;
    endproperty
    a_link_gate: assert property (p_link_gate) else $error("link flag ungated");

    property p_cpdn;
        @(posedge hclk) disable iff (!hresetn)
        $fell(cpgo_q) |-> cpdn_q;
    endproperty
    a_cpdn: assert property (p_cpdn) else $error("copy done not set");

    property p_pkt;
        @(posedge hclk) disable iff (!hresetn)
        flags[5] == (pcnt_q != 8'h00);
    endproperty
    a_pkt: assert property (p_pkt) else $error("pending flag wrong");

    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
        !ien_q[7] |=> !eth_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without global enable");
endmodule

// File: eef_irq_sink.sv
`timescale 1ns/100ps
module eef_irq_sink (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic eth_irq,
    input wire logic core_idle,
    output logic core_woken
);
    // ----------------------------------------
    // core interrupt input
    // ----------------------------------------
    // level input: an idling core wakes on any enabled event, not on an edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            core_woken <= 1'b0;
        else if (core_idle && eth_irq)
            core_woken <= 1'b1;
        else if (!core_idle)
            core_woken <= 1'b0;
    end
endmodule

// File: test_ethernet_event_flags.sv
`timescale 1ns/100ps
module test_ethernet_event_flags;
    // ----------------------------------------
    // stimulus and model state
    // ----------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] ev = 8'h0;
    logic no_room = 1'b0;
    logic [10:0] bytes = 11'h0;
    logic [15:0] flen = 16'h40;
    logic [1:0] ovr = 2'h0;
    logic idle = 1'b0;
    logic hready, irq, treq, cgo, rab, tsw, woke, resp;
    logic [31:0] hrdata, r;
    logic [12:0] taddr, saw_addr, m_txnd;
    logic [31:0] m_flag = 32'h0, m_stat = 32'h0, m_ctrl = 32'h0, m_cnt = 32'h0, m_ien = 32'h0;
    int num_errors = 0;
    int tests_run = 0;
    int seed = 81;
    int n_ra = 0, n_sw = 0, m_ra = 0, m_sw = 0;

    always #25 hclk = ~hclk;

    eef_top u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hrdata(hrdata), .hresp(resp), .rx_pkt_end(ev[0]), .rx_no_room(no_room), .rx_bw_fail(ev[1]),
        .tx_collision(ev[2]), .tx_bytes_sent(bytes), .tx_wait_forever_on_busy_medium_limit(ev[3]), .tx_frame_len(flen),
        .per_packet_override(ovr[1]), .per_packet_huge_allow(ovr[0]), .tx_underrun(ev[4]),
        .tx_complete(ev[5]), .copy_engine_finished(ev[6]), .phy_link_event(ev[7]), .eth_irq(irq),
        .tx_request(treq), .copy_engine_go(cgo), .rx_abort(rab), .tx_status_write(tsw),
        .tx_status_addr(taddr)
    );

    eef_irq_sink u_core (
        .hclk(hclk), .hresetn(hresetn), .eth_irq(irq), .core_idle(idle), .core_woken(woke)
    );

    // abort pulses last one cycle, so count them at every edge
    always @(posedge hclk)
    begin
        if (rab === 1'b1)
            n_ra++;
        if (tsw === 1'b1)
        begin
            n_sw++;
            saw_addr = taddr;
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_sim();
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    task automatic pulse(input int i);
        @(posedge hclk);
        ev <= 8'h1 << i;
        @(posedge hclk);
        ev <= 8'h0;
    endtask

    task automatic check_all();
        logic e;
        repeat (2) @(posedge hclk);
        m_flag[6] = (m_cnt != 0);
        e = m_ien[7] & |(m_flag[6:0] & m_ien[6:0]);
        rd(eef_pkg::OFS_FLAG, r);
        chk("flags", r, m_flag);
        rd(eef_pkg::OFS_STAT, r);
        chk("status", r, m_stat);
        rd(eef_pkg::OFS_CTRL, r);
        chk("ctrl", r, m_ctrl);
        rd(eef_pkg::OFS_PCNT, r);
        chk("pkt_count", r, m_cnt);
        rd(eef_pkg::OFS_IEN, r);
        chk("enables", r, m_ien);
        chk("ctrl_pins", {29'h0, resp, cgo, treq}, {29'h0, 1'b0, m_ctrl[5], m_ctrl[3]});
        chk("eth_irq", {31'h0, irq}, {31'h0, e});
    endtask

    // kind: 0 no end, 1 abort, 2 normal completion
    task automatic tx_case(input int src, input int n, input logic [10:0] b,
        input logic [15:0] mac, input logic [15:0] len, input logic [1:0] ov, input int kind);
        bytes <= b;
        flen <= len;
        ovr <= ov;
        wr(eef_pkg::OFS_MAC, {16'h05ee, mac});
        wr(eef_pkg::OFS_CTRL, 32'h8);
        m_ctrl = 32'h8;
        repeat (n) pulse(src);
        repeat (2) @(posedge hclk);
        if (kind != 0)
        begin
            m_ctrl = 32'h0;
            m_flag[3] = 1'b1;
        end
        if (kind == 1)
        begin
            m_flag[1] = 1'b1;
            m_stat[1] = 1'b1;
            m_sw++;
            if (src == 4)
                m_stat[6] = 1'b1;
        end
        check_all();
        chk("status_writes", 32'(n_sw), 32'(m_sw));
        if (kind == 1)
            chk("status_addr", {19'h0, saw_addr}, {19'h0, m_txnd + 13'h1});
        if (kind == 0)
        begin
            wr(eef_pkg::OFS_CTRL, 32'h0);
            m_ctrl = 32'h0;
            m_flag[3] = 1'b1;
            check_all();
        end
        wr(eef_pkg::OFS_FLAG, 32'h2b);
        wr(eef_pkg::OFS_STAT, 32'h42);
        m_flag = m_flag & ~32'h2b;
        m_stat = 32'h0;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (30000) @(posedge hclk);
        num_errors++;
        end_sim();
    end

    initial
    begin
        m_txnd = 13'($random(seed));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        check_all();
        rd(eef_pkg::OFS_MAC, r);
        chk("max_len", r, 32'h05ee0000);
        wr(8'h40, 32'hffffffff);
        rd(8'h40, r);
        chk("unmapped", r, 32'h0);
        wr(eef_pkg::OFS_TXND, {19'h0, m_txnd});
        repeat (255)
        begin
            pulse(0);
            m_cnt++;
            repeat ({$random(seed)} % 3) @(posedge hclk);
        end
        check_all();
        pulse(0);
        m_flag[0] = 1'b1;
        m_ra++;
        check_all();
        chk("rx_abort", 32'(n_ra), 32'(m_ra));
        repeat (256) wr(eef_pkg::OFS_PDEC, 32'h0);
        m_cnt = 0;
        check_all();
        wr(eef_pkg::OFS_FLAG, 32'h1);
        no_room <= 1'b1;
        pulse(0);
        no_room <= 1'b0;
        m_ra++;
        check_all();
        wr(eef_pkg::OFS_FLAG, 32'h1);
        m_flag[0] = 1'b0;
        check_all();
        pulse(1);
        m_flag[0] = 1'b1;
        m_stat[6] = 1'b1;
        m_ra++;
        check_all();
        chk("rx_abort", 32'(n_ra), 32'(m_ra));
        wr(eef_pkg::OFS_FLAG, 32'h1);
        wr(eef_pkg::OFS_STAT, 32'h40);
        m_flag[0] = 1'b0;
        m_stat = 32'h0;
        tx_case(2, 15, 11'h10, 16'h0, 16'h40, 2'h0, 0);
        tx_case(2, 16, 11'h10, 16'h0, 16'h40, 2'h0, 1);
        tx_case(2, 1, 11'h41, 16'h0, 16'h40, 2'h0, 1);
        tx_case(2, 1, 11'h40, 16'h0, 16'h40, 2'h0, 0);
        tx_case(3, 1, 11'h0, 16'h0, 16'h40, 2'h0, 1);
        tx_case(3, 1, 11'h0, 16'h40, 16'h40, 2'h0, 0);
        tx_case(0, 0, 11'h0, 16'h0, 16'h5ef, 2'h0, 1);
        tx_case(0, 0, 11'h0, 16'h0, 16'h5ee, 2'h0, 0);
        tx_case(0, 0, 11'h0, 16'h4, 16'h5ef, 2'h0, 0);
        tx_case(0, 0, 11'h0, 16'h0, 16'h5ef, 2'h3, 0);
        tx_case(0, 0, 11'h0, 16'h0, 16'h5ef, 2'h2, 1);
        tx_case(4, 1, 11'h0, 16'h0, 16'h40, 2'h0, 1);
        tx_case(5, 1, 11'h0, 16'h0, 16'h40, 2'h0, 2);
        tx_case(2, 16, 11'h41, 16'h1, 16'h40, 2'h0, 0);
        tx_case(3, 1, 11'h0, 16'h1, 16'h40, 2'h0, 0);
        tx_case(4, 1, 11'h0, 16'h1, 16'h40, 2'h0, 1);
        tx_case(0, 0, 11'h0, 16'h1, 16'h5ef, 2'h0, 1);
        flen <= 16'h40;
        wr(eef_pkg::OFS_CTRL, 32'h20);
        m_ctrl = 32'h20;
        pulse(6);
        m_ctrl = 32'h0;
        m_flag[5] = 1'b1;
        check_all();
        wr(eef_pkg::OFS_FLAG, 32'h20);
        wr(eef_pkg::OFS_CTRL, 32'h20);
        wr(eef_pkg::OFS_CTRL, 32'h0);
        check_all();
        pulse(7);
        check_all();
        rd(eef_pkg::OFS_PHY_INT_STATUS_REG, r);
        wr(eef_pkg::OFS_PHYC, 32'h3);
        pulse(7);
        m_flag[4] = 1'b1;
        wr(eef_pkg::OFS_FLAG, 32'h10);
        check_all();
        rd(eef_pkg::OFS_PHY_INT_STATUS_REG, r);
        chk("phy_flags", r & 32'hc, 32'hc);
        m_flag[4] = 1'b0;
        check_all();
        // every source set, then rxer, txer, txdn and cpdn dropped one by one under random enables
        wr(eef_pkg::OFS_CTRL, 32'h8);
        pulse(4);
        m_flag = m_flag | 32'ha;
        m_stat = 32'h42;
        m_sw++;
        pulse(1);
        m_flag[0] = 1'b1;
        pulse(7);
        m_flag[4] = 1'b1;
        wr(eef_pkg::OFS_CTRL, 32'h20);
        wr(eef_pkg::OFS_CTRL, 32'h0);
        m_flag[5] = 1'b1;
        pulse(0);
        m_cnt = 1;
        for (int i = 0; i < 6; i++)
        begin
            repeat (3)
            begin
                m_ien = {$random(seed)} & 32'hfb;
                wr(eef_pkg::OFS_IEN, m_ien);
                check_all();
            end
            wr(eef_pkg::OFS_FLAG, 32'h1 << i);
            if (i != 4)
                m_flag[i] = 1'b0;
        end
        rd(eef_pkg::OFS_PHY_INT_STATUS_REG, r);
        m_flag[4] = 1'b0;
        wr(eef_pkg::OFS_PDEC, 32'h0);
        m_cnt = 0;
        m_ien = 32'hc0;
        wr(eef_pkg::OFS_IEN, m_ien);
        idle <= 1'b1;
        check_all();
        chk("core_asleep", {31'h0, woke}, 32'h0);
        pulse(0);
        m_cnt = 1;
        check_all();
        chk("core_woken", {31'h0, woke}, 32'h1);
        // second reset in mid-run
        hresetn <= 1'b0;
        idle <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        m_flag = 32'h0;
        m_stat = 32'h0;
        m_cnt = 0;
        m_ien = 32'h0;
        check_all();
        end_sim();
    end
endmodule
